/* File: sim/pfs_far_side.sv */
// Far-side model: switches or PLC on the command pins, plus sensor lines
`timescale 1ns/100ps
module pfs_far_side (
    input wire logic i_clk,
    input wire logic [7:0] i_cmd,
    input wire logic [1:0] i_brk,
    input wire logic [11:0] i_preset,
    input wire logic [11:0] i_actual,
    output logic [7:0] o_din,
    output logic o_pot_pre,
    output logic o_pot_act,
    output logic [11:0] o_adc_preset,
    output logic [11:0] o_adc_actual
);
    // Commands arrive active high; start and stop pins are pulled to ground when active
    always @(posedge i_clk) begin
        o_din <= i_cmd ^ 8'h03;
        o_pot_pre <= i_brk[0];
        o_pot_act <= i_brk[1];
        o_adc_preset <= i_preset;
        o_adc_actual <= i_actual;
    end
endmodule : pfs_far_side

/* File: sim/pfs_input_sequencer_checker.sv */
// Port-level assertions for the input sequencer
`timescale 1ns/100ps
module pfs_input_sequencer_checker #(
    parameter int CB_DETECT_CYC = 20
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    input wire logic [7:0] i_din,
    input wire logic o_wb_ack,
    input wire logic o_setpoint_run,
    input wire logic [2:0] o_setpoint_sel,
    input wire logic o_loop_closed,
    input wire logic o_ramp_bypass,
    input wire logic o_sol_a_en,
    input wire logic o_sol_b_en,
    input wire logic o_direct_a,
    input wire logic o_direct_b,
    input wire logic [11:0] o_direct_cur,
    input wire logic o_fault_led,
    input wire logic o_error
);
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_rst);
    sequence s_ack_pulse;
        o_wb_ack ##1 !o_wb_ack;
    endsequence
    sequence s_run_req;
        (!i_din[0] && i_din[1]) [*3];
    endsequence
    sequence s_run_off;
        (i_din[0] || !i_din[1]) [*3];
    endsequence
    a_ack_one_pulse: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack |=> s_ack_pulse)
        else $error("ack not a one-cycle pulse after request");
    a_run_on_start: assert property (s_run_req |=> o_setpoint_run)
        else $error("run missing with start active and stop inactive");
    a_run_off_stop: assert property (s_run_off |=> !o_setpoint_run)
        else $error("run active without start or with stop");
    a_sel_held: assert property (s_run_off |=> $stable(o_setpoint_sel))
        else $error("selection changed while not running");
    a_enable_gates: assert property (!i_din[2] [*3] |=> !o_sol_a_en && !o_sol_b_en)
        else $error("solenoid released without enable");
    a_break_blocks: assert property (o_fault_led |-> !o_sol_a_en && !o_sol_b_en && o_error)
        else $error("cable break without blocking and error");
    a_ramp_off_in: assert property (i_din[4] [*3] |=> o_ramp_bypass)
        else $error("ramp not bypassed with ramp-off input");
    a_direct_open: assert property (o_direct_a || o_direct_b |-> !o_loop_closed)
        else $error("loop closed while driving directly");
    a_direct_cur_idle: assert property (!o_direct_a && !o_direct_b |-> o_direct_cur == 12'h000)
        else $error("direct current nonzero while idle");
endmodule : pfs_input_sequencer_checker
bind pfs_input_sequencer pfs_input_sequencer_checker #(.CB_DETECT_CYC(CB_DETECT_CYC))
    pfs_input_sequencer_checker_inst (.i_clk, .i_rst, .i_wb_cyc, .i_wb_stb, .i_din, .o_wb_ack,
    .o_setpoint_run, .o_setpoint_sel, .o_loop_closed, .o_ramp_bypass, .o_sol_a_en, .o_sol_b_en,
    .o_direct_a, .o_direct_b, .o_direct_cur, .o_fault_led, .o_error);

/* File: sim/testbench.sv */
// Self-checking bench: Wishbone register access and command-pin sequences
`timescale 1ns/100ps
`include "pfs_map.svh"
module testbench;
    logic i_clk, i_rst, cyc, stb, we, ack, run, lc, rb, sa, sb, da, db, led, err, pp, pa;
    logic [7:0] adr, cmd, din;
    logic [3:0] sel;
    logic [31:0] dat, rdat, q;
    logic [1:0] brk;
    logic [2:0] ssel;
    logic [11:0] pre, act, ap, aa, cur;
    int fail_count = 0;
    int n_compared = 0;
    pfs_input_sequencer #(.CB_DETECT_CYC(20)) pfs_input_sequencer_inst (.i_clk(i_clk),
        .i_rst(i_rst), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr),
        .i_wb_sel(sel), .i_wb_dat(dat), .o_wb_dat(rdat), .o_wb_ack(ack), .i_din(din),
        .i_pot_break_pre(pp), .i_pot_break_act(pa), .i_adc_preset(ap), .i_adc_actual(aa),
        .o_setpoint_run(run), .o_setpoint_sel(ssel), .o_loop_closed(lc), .o_ramp_bypass(rb),
        .o_sol_a_en(sa), .o_sol_b_en(sb), .o_direct_a(da), .o_direct_b(db),
        .o_direct_cur(cur), .o_fault_led(led), .o_error(err));
    pfs_far_side pfs_far_side_inst (.i_clk(i_clk), .i_cmd(cmd), .i_brk(brk), .i_preset(pre),
        .i_actual(act), .o_din(din), .o_pot_pre(pp), .o_pot_act(pa), .o_adc_preset(ap),
        .o_adc_actual(aa));
    initial begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end
    task final_report;
        if (fail_count == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : final_report
    task chk(input logic [31:0] g, input logic [31:0] e);
        n_compared++;
        if (g !== e) begin
            fail_count++;
            $display("ERROR %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk
    task cyc_n(input int n);
        repeat (n) @(posedge i_clk);
    endtask : cyc_n
    task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        do begin
            @(posedge i_clk);
            n++;
        end while (ack !== 1'b1 && n < 20);
        q = rdat;
        if (n >= 20) begin
            fail_count++;
            $display("ERROR %0t: no bus answer", $time);
        end
        cyc <= 1'b0;
        stb <= 1'b0;
        cyc_n(2);
    endtask : wb
    task wr(input logic [7:0] a, input logic [31:0] d);
        wb(1'b1, a, d);
    endtask : wr
    task rd(input logic [7:0] a, input logic [31:0] e);
        wb(1'b0, a, 32'h0000_0000);
        chk(q, e);
    endtask : rd
    task set_cmd(input logic [7:0] v);
        cmd <= v;
        cyc_n(6);
    endtask : set_cmd
    initial begin
        #300000;
        fail_count++;
        final_report();
    end
    initial begin
        i_rst = 1'b1;
        {cyc, stb, we} = 3'h0;
        adr = 8'h00;
        sel = 4'hF;
        dat = 32'h0000_0000;
        cmd = 8'h00;
        brk = 2'h0;
        pre = 12'h800;
        act = 12'h000;
        cyc_n(6);
        i_rst <= 1'b0;
        cyc_n(3);
        for (int i = 0; i < 5; i++) rd(8'(i * 4), 32'h0000_0000);
        chk(rb, 1'b1);
        wr(8'h3C, 32'hFFFF_FFFF);
        rd(8'h3C, 32'h0000_0000);
        wr(`PFS_ADR_RAMP, 32'h0000_0005);
        chk(rb, 1'b0);
        set_cmd(8'h10);
        chk(rb, 1'b1);
        set_cmd(8'h05);
        chk({run, sa, sb}, 3'h7);
        // Start held active while the selection inputs walk all codes
        for (int i = 0; i < 8; i++) begin
            set_cmd({i[2:0], 5'h05});
            chk(ssel, i);
        end
        set_cmd(8'h04);
        chk(ssel, 3'h7);
        set_cmd(8'h07);
        chk({run, ssel}, 4'h7);
        set_cmd(8'h01);
        chk({sa, sb}, 2'h0);
        wr(`PFS_ADR_CTRL, 32'h0000_0020);
        set_cmd(8'h0D);
        chk(lc, 1'b0);
        set_cmd(8'h05);
        chk(lc, 1'b1);
        wr(`PFS_ADR_CTRL, 32'h0000_0000);
        set_cmd(8'h0D);
        chk(lc, 1'b1);
        set_cmd(8'h05);
        wr(`PFS_ADR_CABLE, 32'h0000_0003);
        pre <= 12'h000;
        cyc_n(10);
        chk({led, sa}, 2'h1);
        cyc_n(30);
        chk({led, err, sa, sb}, 4'hC);
        pre <= 12'h800;
        cyc_n(6);
        chk(led, 1'b0);
        wr(`PFS_ADR_CABLE, 32'h0000_0001);
        pre <= 12'h000;
        cyc_n(40);
        chk(led, 1'b0);
        pre <= 12'h800;
        wr(`PFS_ADR_CABLE, 32'h0000_0005);
        brk <= 2'h1;
        cyc_n(40);
        chk(led, 1'b0);
        wr(`PFS_ADR_CTRL, 32'h8000_0000);
        cyc_n(40);
        chk(led, 1'b1);
        brk <= 2'h0;
        wr(`PFS_ADR_CABLE, 32'h0000_0000);
        wr(`PFS_ADR_CURRENT, 32'h0456_0123);
        wr(`PFS_ADR_THRESH, 32'h0000_0102);
        act <= 12'h101;
        wr(`PFS_ADR_CTRL, 32'h0000_0006);
        set_cmd(8'h85);
        chk({da, lc, sb, cur}, 15'h4123);
        act <= 12'h103;
        cyc_n(5);
        chk(da, 1'b1);
        wr(`PFS_ADR_CTRL, 32'h0000_0106);
        cyc_n(3);
        chk({da, lc}, 2'h1);
        set_cmd(8'hC5);
        chk({db, sa, sb, lc, cur}, 16'hA456);
        set_cmd(8'h85);
        chk({sa, sb, da, db}, 4'h0);
        act <= 12'h101;
        set_cmd(8'h05);
        set_cmd(8'h85);
        chk(da, 1'b1);
        set_cmd(8'h25);
        chk(ssel, 3'h1);
        final_report();
    end
endmodule : testbench

/* File: src/pfs_cb_detect.sv */
// Cable-break qualifier: a break must persist for the detection time
`timescale 1ns/100ps
`include "pfs_map.svh"
module pfs_cb_detect #(
    parameter int DETECT_CYC = `PFS_CB_DETECT_CYC
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_enable,
    input wire logic i_raw_break,
    output logic o_broken
);

    typedef struct packed {
        logic [`PFS_CB_CNT_W-1:0] cnt;
        logic broken;
    } pfs_cbd_type;

    localparam logic [`PFS_CB_CNT_W-1:0] LAST = `PFS_CB_CNT_W'(DETECT_CYC - 1);

    pfs_cbd_type q;
    pfs_cbd_type d;

    always_comb begin
        d = q;
        if (!i_enable || !i_raw_break) begin
            d.cnt = '0;
            d.broken = 1'b0;
        end else if (q.cnt == LAST) begin
            d.broken = 1'b1;
        end else begin
            // Outputs stay unblocked while the break is still being qualified
            d.cnt = q.cnt + 1'b1;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign o_broken = q.broken;

endmodule : pfs_cb_detect

/* File: src/pfs_input_sequencer.sv */
// Digital input and mode sequencer of a pressure/flow valve controller
//
// Summary of operation
// - Inputs one and two are active low; inputs three to eight active high.
// - Analog samples keep 10 or 12 significant bits depending on card variant.
// - A detected cable break blocks the solenoids and raises fault lamp and error.
// - Break detection runs only when enabled and input is 4-20 mA or potentiometer.
// - Potentiometer break detection takes effect only after a restart.
// - A break is recognised after about 100 ms; until then outputs stay live.
// - While start is active the setpoint changes, source chosen by inputs six-eight.
// - With start inactive the current selection is held.
// - Start held permanently active adopts every selection change at once.
// - Stop active halts setpoint changes; releasing stop allows them again.
// - Solenoid motion is allowed only while enable input three is active.
// - Input four switches regulation off, giving an open-loop amplifier.
// - Input four acts only when the loop mode is external.
// - Input five bypasses the setpoint ramp.
// - A ramp time of zero disables the ramp without input five.
// - Controller type sets the meaning of inputs six to eight; type 6 is clamping.
// - In clamping mode input six selects the single profile over the external preset.
// - Clamping input seven drives the unloading solenoid open-loop at backward current.
// - Clamping input eight drives open-loop until the threshold, then regulates.
// - After backward release both valves stay off until forward is re-applied or backward is applied again.
// - External mode regulates with input four inactive, open loop when active.
// - The error output is active whenever any error is present.
`timescale 1ns/100ps
`include "pfs_map.svh"
module pfs_input_sequencer #(
    parameter int CB_DETECT_CYC = `PFS_CB_DETECT_CYC
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    input wire logic i_wb_we,
    input wire logic [7:0] i_wb_adr,
    input wire logic [3:0] i_wb_sel,
    input wire logic [31:0] i_wb_dat,
    output logic [31:0] o_wb_dat,
    output logic o_wb_ack,
    input wire logic [7:0] i_din,
    input wire logic i_pot_break_pre,
    input wire logic i_pot_break_act,
    input wire logic [11:0] i_adc_preset,
    input wire logic [11:0] i_adc_actual,
    output logic o_setpoint_run,
    output logic [2:0] o_setpoint_sel,
    output logic o_loop_closed,
    output logic o_ramp_bypass,
    output logic o_sol_a_en,
    output logic o_sol_b_en,
    output logic o_direct_a,
    output logic o_direct_b,
    output logic [11:0] o_direct_cur,
    output logic o_fault_led,
    output logic o_error
);

    pfs_pkg::pfs_main_type q;
    pfs_pkg::pfs_main_type d;

    logic [9:0] pins_sync;
    logic [7:0] din_act;
    logic [11:0] pre_samp;
    logic [11:0] act_samp;
    logic pre_raw;
    logic act_raw;
    logic pre_det_en;
    logic act_det_en;
    logic brk_pre;
    logic brk_act;
    logic fault;

    function automatic logic [31:0] pfs_merge(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0] sel);
        logic [31:0] m;
        m = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
        return (old_v & ~m) | (new_v & m);
    endfunction : pfs_merge

    // Pins come from switches or a controller outside this clock
    pfs_sync2 #(
        .W(10),
        .RST_VAL(`PFS_SYNC_RST)
    ) u_sync (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_async({i_pot_break_act, i_pot_break_pre, i_din}),
        .o_sync(pins_sync)
    );

    assign din_act = pins_sync[7:0] ^ `PFS_DIN_LOW_ACTIVE;

    // A 10-bit converter leaves the two lowest bits without meaning
    assign pre_samp = q.adc12 ? i_adc_preset : (i_adc_preset & `PFS_ADC10_MASK);
    assign act_samp = q.adc12 ? i_adc_actual : (i_adc_actual & `PFS_ADC10_MASK);

    always_comb begin
        pre_raw = ((q.cb_pre_kind == `PFS_KIND_CUR) && (pre_samp < `PFS_CB_CUR_LEVEL))
                  || ((q.cb_pre_kind == `PFS_KIND_POT) && pins_sync[8]);
        act_raw = ((q.cb_act_kind == `PFS_KIND_CUR) && (act_samp < `PFS_CB_CUR_LEVEL))
                  || ((q.cb_act_kind == `PFS_KIND_POT) && pins_sync[9]);
        pre_det_en = q.cb_pre_en && ((q.cb_pre_kind == `PFS_KIND_CUR)
                     || ((q.cb_pre_kind == `PFS_KIND_POT) && q.pot_arm_pre));
        act_det_en = q.cb_act_en && ((q.cb_act_kind == `PFS_KIND_CUR)
                     || ((q.cb_act_kind == `PFS_KIND_POT) && q.pot_arm_act));
    end

    pfs_cb_detect #(
        .DETECT_CYC(CB_DETECT_CYC)
    ) u_cb_pre (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_enable(pre_det_en),
        .i_raw_break(pre_raw),
        .o_broken(brk_pre)
    );

    pfs_cb_detect #(
        .DETECT_CYC(CB_DETECT_CYC)
    ) u_cb_act (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_enable(act_det_en),
        .i_raw_break(act_raw),
        .o_broken(brk_act)
    );

    assign fault = brk_pre | brk_act;

    always_comb begin
        logic req;
        logic is_clamp;
        logic start_ok;
        logic ext_loop;
        logic energise;
        logic [2:0] want_sel;
        logic [7:0] word;
        logic [31:0] img_ctrl;
        logic [31:0] img_cable;
        logic [31:0] img_ramp;
        logic [31:0] img_cur;
        logic [31:0] img_thr;
        logic [31:0] img_stat;
        logic [31:0] w;
        req = 1'b0;
        is_clamp = 1'b0;
        start_ok = 1'b0;
        ext_loop = 1'b0;
        energise = 1'b0;
        want_sel = '0;
        word = '0;
        img_ctrl = '0;
        img_cable = '0;
        img_ramp = '0;
        img_cur = '0;
        img_thr = '0;
        img_stat = '0;
        w = '0;
        d = q;

        // Register images as software sees them
        img_ctrl[`PFS_CTRL_TYPE] = q.ctrl_type;
        img_ctrl[`PFS_CTRL_LOOP] = q.loop_mode;
        img_ctrl[`PFS_CTRL_ADC12] = q.adc12;
        img_cable[`PFS_CABLE_PRE_EN] = q.cb_pre_en;
        img_cable[`PFS_CABLE_PRE_KIND] = q.cb_pre_kind;
        img_cable[`PFS_CABLE_ACT_EN] = q.cb_act_en;
        img_cable[`PFS_CABLE_ACT_KIND] = q.cb_act_kind;
        img_ramp[`PFS_RAMP_TIME] = q.ramp_time;
        img_cur[`PFS_CUR_FWD] = q.fwd_cur;
        img_cur[`PFS_CUR_BWD] = q.bwd_cur;
        img_thr[`PFS_THRESH_VAL] = q.thresh;
        img_stat[`PFS_STAT_DIN] = din_act;
        img_stat[`PFS_STAT_SEL] = q.sel;
        img_stat[`PFS_STAT_CLAMP] = q.clamp;
        img_stat[`PFS_STAT_BRK_PRE] = brk_pre;
        img_stat[`PFS_STAT_BRK_ACT] = brk_act;
        img_stat[`PFS_STAT_LOOP] = q.loop_closed;
        img_stat[`PFS_STAT_RUN] = q.run;

        // Wishbone slave: one wait state, ack dropped the cycle after it
        req = i_wb_cyc && i_wb_stb && !q.ack;
        word = {i_wb_adr[`PFS_ADR_WORD], 2'b00};
        d.ack = req;
        if (req && !i_wb_we) begin
            case (word)
                `PFS_ADR_CTRL: d.rdat = img_ctrl;
                `PFS_ADR_CABLE: d.rdat = img_cable;
                `PFS_ADR_RAMP: d.rdat = img_ramp;
                `PFS_ADR_CURRENT: d.rdat = img_cur;
                `PFS_ADR_THRESH: d.rdat = img_thr;
                `PFS_ADR_STATUS: d.rdat = img_stat;
                default: d.rdat = '0;
            endcase
        end
        if (req && i_wb_we) begin
            case (word)
                `PFS_ADR_CTRL: begin
                    w = pfs_merge(img_ctrl, i_wb_dat, i_wb_sel);
                    d.ctrl_type = w[`PFS_CTRL_TYPE];
                    d.loop_mode = w[`PFS_CTRL_LOOP];
                    d.adc12 = w[`PFS_CTRL_ADC12];
                    // A restart re-reads the potentiometer break enables
                    if (w[`PFS_CTRL_RESTART]) begin
                        d.arm_done = 1'b0;
                    end
                end
                `PFS_ADR_CABLE: begin
                    w = pfs_merge(img_cable, i_wb_dat, i_wb_sel);
                    d.cb_pre_en = w[`PFS_CABLE_PRE_EN];
                    d.cb_pre_kind = w[`PFS_CABLE_PRE_KIND];
                    d.cb_act_en = w[`PFS_CABLE_ACT_EN];
                    d.cb_act_kind = w[`PFS_CABLE_ACT_KIND];
                end
                `PFS_ADR_RAMP: begin
                    w = pfs_merge(img_ramp, i_wb_dat, i_wb_sel);
                    d.ramp_time = w[`PFS_RAMP_TIME];
                end
                `PFS_ADR_CURRENT: begin
                    w = pfs_merge(img_cur, i_wb_dat, i_wb_sel);
                    d.fwd_cur = w[`PFS_CUR_FWD];
                    d.bwd_cur = w[`PFS_CUR_BWD];
                end
                `PFS_ADR_THRESH: begin
                    w = pfs_merge(img_thr, i_wb_dat, i_wb_sel);
                    d.thresh = w[`PFS_THRESH_VAL];
                end
                default: begin
                    w = '0;
                end
            endcase
        end

        // Potentiometer detection arms only on the first cycle after reset or a restart
        if (!q.arm_done) begin
            d.arm_done = 1'b1;
            d.pot_arm_pre = q.cb_pre_en && (q.cb_pre_kind == `PFS_KIND_POT);
            d.pot_arm_act = q.cb_act_en && (q.cb_act_kind == `PFS_KIND_POT);
        end

        // Setpoint selection and run gating
        is_clamp = (q.ctrl_type == `PFS_TYPE_CLAMP);
        want_sel = is_clamp ? {2'b00, din_act[`PFS_DIN_SEL_LO]} : din_act[`PFS_DIN_SEL];
        start_ok = din_act[`PFS_DIN_START] && !din_act[`PFS_DIN_STOP];
        d.run = start_ok;
        if (start_ok) begin
            d.sel = want_sel;
        end else begin
            d.sel = q.sel;
        end

        // Clamping sequence; leaves it idle in every other controller type
        if (!is_clamp || !din_act[`PFS_DIN_ENABLE]) begin
            d.clamp = pfs_pkg::PFS_CL_IDLE;
        end else begin
            case (q.clamp)
                pfs_pkg::PFS_CL_IDLE: begin
                    if (din_act[`PFS_DIN_BACK]) begin
                        d.clamp = pfs_pkg::PFS_CL_BACK;
                    end else if (din_act[`PFS_DIN_FWD]) begin
                        d.clamp = pfs_pkg::PFS_CL_FWD;
                    end
                end
                pfs_pkg::PFS_CL_FWD: begin
                    if (din_act[`PFS_DIN_BACK]) begin
                        d.clamp = pfs_pkg::PFS_CL_BACK;
                    end else if (!din_act[`PFS_DIN_FWD]) begin
                        d.clamp = pfs_pkg::PFS_CL_IDLE;
                    end else if (act_samp >= q.thresh) begin
                        d.clamp = pfs_pkg::PFS_CL_REG;
                    end
                end
                pfs_pkg::PFS_CL_REG: begin
                    if (din_act[`PFS_DIN_BACK]) begin
                        d.clamp = pfs_pkg::PFS_CL_BACK;
                    end else if (!din_act[`PFS_DIN_FWD]) begin
                        d.clamp = pfs_pkg::PFS_CL_IDLE;
                    end
                end
                pfs_pkg::PFS_CL_BACK: begin
                    if (!din_act[`PFS_DIN_BACK]) begin
                        d.clamp = pfs_pkg::PFS_CL_HOLD;
                    end
                end
                pfs_pkg::PFS_CL_HOLD: begin
                    // Forward must drop before it can start a new sequence
                    if (din_act[`PFS_DIN_BACK]) begin
                        d.clamp = pfs_pkg::PFS_CL_BACK;
                    end else if (!din_act[`PFS_DIN_FWD]) begin
                        d.clamp = pfs_pkg::PFS_CL_IDLE;
                    end
                end
                default: begin
                    d.clamp = pfs_pkg::PFS_CL_IDLE;
                end
            endcase
        end

        // Loop mode: external mode hands the choice to input four
        case (q.loop_mode)
            `PFS_LOOP_ON: ext_loop = 1'b1;
            `PFS_LOOP_EXT: ext_loop = !din_act[`PFS_DIN_LOOP_OFF];
            default: ext_loop = 1'b0;
        endcase
        d.loop_closed = ext_loop && (!is_clamp || (d.clamp == pfs_pkg::PFS_CL_REG));
        d.ramp_bypass = din_act[`PFS_DIN_RAMP_OFF] || (q.ramp_time == `PFS_RAMP_ZERO);

        // Solenoid release: enable present, no fault, and in clamping type a clamp sequence active
        energise = din_act[`PFS_DIN_ENABLE] && !fault
                   && (!is_clamp || (d.clamp == pfs_pkg::PFS_CL_FWD)
                       || (d.clamp == pfs_pkg::PFS_CL_REG)
                       || (d.clamp == pfs_pkg::PFS_CL_BACK));
        d.sol_a_en = energise && !(is_clamp && (d.clamp == pfs_pkg::PFS_CL_BACK));
        d.sol_b_en = energise && !(is_clamp && (d.clamp == pfs_pkg::PFS_CL_FWD));
        d.direct_a = energise && is_clamp && (d.clamp == pfs_pkg::PFS_CL_FWD);
        d.direct_b = energise && is_clamp && (d.clamp == pfs_pkg::PFS_CL_BACK);
        if (d.direct_b) begin
            d.direct_cur = q.bwd_cur;
        end else if (d.direct_a) begin
            d.direct_cur = q.fwd_cur;
        end else begin
            d.direct_cur = '0;
        end
        d.fault_led = fault;
        d.error = fault;
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign o_wb_dat = q.rdat;
    assign o_wb_ack = q.ack;
    assign o_setpoint_run = q.run;
    assign o_setpoint_sel = q.sel;
    assign o_loop_closed = q.loop_closed;
    assign o_ramp_bypass = q.ramp_bypass;
    assign o_sol_a_en = q.sol_a_en;
    assign o_sol_b_en = q.sol_b_en;
    assign o_direct_a = q.direct_a;
    assign o_direct_b = q.direct_b;
    assign o_direct_cur = q.direct_cur;
    assign o_fault_led = q.fault_led;
    assign o_error = q.error;

endmodule : pfs_input_sequencer

/* File: src/pfs_map.svh */
// Register map, field positions, encodings and timing for the input sequencer
`ifndef PFS_MAP_SVH
`define PFS_MAP_SVH

// Register byte addresses (one aligned 32-bit word each)
`define PFS_ADR_CTRL 8'h00
`define PFS_ADR_CABLE 8'h04
`define PFS_ADR_RAMP 8'h08
`define PFS_ADR_CURRENT 8'h0C
`define PFS_ADR_THRESH 8'h10
`define PFS_ADR_STATUS 8'h14
`define PFS_ADR_WORD 7:2

// CTRL fields
`define PFS_CTRL_TYPE 2:0
`define PFS_CTRL_LOOP 5:4
`define PFS_CTRL_ADC12 8
`define PFS_CTRL_RESTART 31

// CABLE fields
`define PFS_CABLE_PRE_EN 0
`define PFS_CABLE_PRE_KIND 2:1
`define PFS_CABLE_ACT_EN 4
`define PFS_CABLE_ACT_KIND 6:5

// RAMP, CURRENT and THRESH fields
`define PFS_RAMP_TIME 15:0
`define PFS_CUR_FWD 11:0
`define PFS_CUR_BWD 27:16
`define PFS_THRESH_VAL 11:0

// STATUS fields
`define PFS_STAT_DIN 7:0
`define PFS_STAT_SEL 10:8
`define PFS_STAT_CLAMP 14:12
`define PFS_STAT_BRK_PRE 16
`define PFS_STAT_BRK_ACT 17
`define PFS_STAT_LOOP 18
`define PFS_STAT_RUN 19

// Digital inputs: index 0 is input 1
`define PFS_DIN_LOW_ACTIVE 8'h03
`define PFS_DIN_START 0
`define PFS_DIN_STOP 1
`define PFS_DIN_ENABLE 2
`define PFS_DIN_LOOP_OFF 3
`define PFS_DIN_RAMP_OFF 4
`define PFS_DIN_SEL_LO 5
`define PFS_DIN_BACK 6
`define PFS_DIN_FWD 7
`define PFS_DIN_SEL 7:5
`define PFS_SYNC_RST 10'h003

// Controller type and loop mode encodings
`define PFS_TYPE_CLAMP 3'h6
`define PFS_LOOP_ON 2'h0
`define PFS_LOOP_OFF 2'h1
`define PFS_LOOP_EXT 2'h2

// Cable-break input kinds
`define PFS_KIND_VOLT 2'h0
`define PFS_KIND_CUR 2'h1
`define PFS_KIND_POT 2'h2

// Current-loop level below which a 4..20 mA line counts as open
`define PFS_CB_CUR_LEVEL 12'h19A
`define PFS_ADC10_MASK 12'hFFC
`define PFS_RAMP_ZERO 16'h0000

// Timing
`define PFS_CLK_PERIOD_NS 10
`define PFS_CB_DETECT_NS 100000000
`define PFS_CB_DETECT_CYC (`PFS_CB_DETECT_NS / `PFS_CLK_PERIOD_NS)
`define PFS_CB_CNT_W 24

`endif

/* File: src/pfs_pkg.sv */
// Types shared by the input sequencer modules
package pfs_pkg;

    typedef enum logic [2:0] {
        PFS_CL_IDLE = 3'h0,
        PFS_CL_FWD = 3'h1,
        PFS_CL_REG = 3'h3,
        PFS_CL_BACK = 3'h2,
        PFS_CL_HOLD = 3'h6
    } pfs_clamp_type;

    typedef struct packed {
        logic ack;
        logic [31:0] rdat;
        logic [2:0] ctrl_type;
        logic [1:0] loop_mode;
        logic adc12;
        logic cb_pre_en;
        logic [1:0] cb_pre_kind;
        logic cb_act_en;
        logic [1:0] cb_act_kind;
        logic [15:0] ramp_time;
        logic [11:0] fwd_cur;
        logic [11:0] bwd_cur;
        logic [11:0] thresh;
        logic arm_done;
        logic pot_arm_pre;
        logic pot_arm_act;
        pfs_clamp_type clamp;
        logic [2:0] sel;
        logic run;
        logic loop_closed;
        logic ramp_bypass;
        logic sol_a_en;
        logic sol_b_en;
        logic direct_a;
        logic direct_b;
        logic [11:0] direct_cur;
        logic fault_led;
        logic error;
    } pfs_main_type;

endpackage : pfs_pkg

/* File: src/pfs_sync2.sv */
// Two-flop synchroniser for a group of asynchronous input pins
`timescale 1ns/100ps
module pfs_sync2 #(
    parameter int W = 10,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic [W-1:0] i_async,
    output logic [W-1:0] o_sync
);

    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } pfs_sync_type;

    pfs_sync_type q;
    pfs_sync_type d;

    always_comb begin
        d.s1 = i_async;
        d.s2 = q.s1;
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            q.s1 <= RST_VAL;
            q.s2 <= RST_VAL;
        end else begin
            q <= d;
        end
    end

    assign o_sync = q.s2;

endmodule : pfs_sync2
